// *** hdl/sea_defines.svh ***
// constants of the serial EEPROM slave
`ifndef SEA_DEFINES_SVH
`define SEA_DEFINES_SVH

`define SEA_OP_READ       8'h03
`define SEA_OP_WRITE      8'h02
`define SEA_OP_PERMIT     8'h06
`define SEA_OP_REVOKE     8'h04
`define SEA_ADDR_W        15
`define SEA_PAGE_BITS     6
`define SEA_WORD_AW       13
`define SEA_PAGE_WORD_AW  4
`define SEA_BYTE_SEL_W    2
`define SEA_WORD_BITS     32
`define SEA_CHK_BITS      6
`define SEA_CW_BITS       38
`define SEA_ERASED_WORD   32'hFFFF_FFFF
`define SEA_CLK_MHZ       25
`define SEA_PROG_TIME_US  1000
`define SEA_SEQ_LAST      3'h5
`define SEA_BUF_DEPTH     2
`define SEA_REGION_ALL    2'h3
`define SEA_REGION_HALF   2'h2
`define SEA_REGION_QUART  2'h1

`endif

// *** hdl/sea_pkg.sv ***
// types and check-bit functions of the serial EEPROM slave
`include "sea_defines.svh"

package sea_pkg;

  typedef struct packed {
    logic lock;
    logic hi;
    logic lo;
  } sea_status_s;

  typedef struct packed {
    logic [`SEA_CHK_BITS-1:0]  chk;
    logic [`SEA_WORD_BITS-1:0] data;
  } sea_cw_s;

  typedef enum logic [6:0] {
    PH_IDLE = 7'b000_0001,
    PH_OPC  = 7'b000_0010,
    PH_ADDR = 7'b000_0100,
    PH_RDAT = 7'b000_1000,
    PH_WDAT = 7'b001_0000,
    PH_CMD  = 7'b010_0000,
    PH_SKIP = 7'b100_0000
  } sea_state_e;

  // hamming layout: check bit i at position 2**i
  function automatic sea_cw_s sea_ecc_encode(input logic [`SEA_WORD_BITS-1:0] data);
    logic [`SEA_CW_BITS:1] cw;
    sea_cw_s               res;
    int                    j;
    cw  = '0;
    res = '0;
    j   = 0;
    for (int p = 1; p <= `SEA_CW_BITS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = data[j];
        j++;
      end
    end
    for (int i = 0; i < `SEA_CHK_BITS; i++)
      for (int p = 1; p <= `SEA_CW_BITS; p++)
        if (p[i])
          res.chk[i] = res.chk[i] ^ cw[p];
    res.data = data;
    return res;
  endfunction

  // single-bit correction from the syndrome
  function automatic logic [`SEA_WORD_BITS-1:0] sea_ecc_decode(input sea_cw_s w);
    logic [`SEA_CW_BITS:1]     cw;
    logic [`SEA_CHK_BITS-1:0]  syn;
    logic [`SEA_WORD_BITS-1:0] res;
    int                        j;
    cw  = '0;
    syn = '0;
    res = '0;
    j   = 0;
    for (int p = 1; p <= `SEA_CW_BITS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = w.data[j];
        j++;
      end
    end
    for (int i = 0; i < `SEA_CHK_BITS; i++)
      cw[1 << i] = w.chk[i];
    for (int p = 1; p <= `SEA_CW_BITS; p++)
      if (cw[p])
        syn = syn ^ `SEA_CHK_BITS'(p);
    if (syn != '0 && int'(syn) <= `SEA_CW_BITS)
      cw[syn] = ~cw[syn];
    j = 0;
    for (int p = 1; p <= `SEA_CW_BITS; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        res[j] = cw[p];
        j++;
      end
    end
    return res;
  endfunction

endpackage

// *** hdl/sea_mem.sv ***
// single-port synchronous memory with registered read data
module sea_mem #(
  parameter int               WIDTH = 8,
  parameter int               AW    = 6,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock
  input  wire logic             clk_i,
  // access port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  localparam int DEPTH = 1 << AW;

  logic [WIDTH-1:0] mem [DEPTH];

  // contents as delivered
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      mem[i] = INIT;
  end

  // plain always: the start-up fill above writes mem as well
  always @(posedge clk_i)
  begin
    if (we_i)
      mem[addr_i] <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem[addr_i];
  end

endmodule

// *** hdl/sea_spi_eeprom.sv ***
// serial EEPROM slave: decode, read streaming, page program with check bits
`include "sea_defines.svh"

// Overview of operation
// - read opcode, address, then stream stored byte
// - address bit fifteen is ignored
// - read pointer advances after every byte
// - read pointer wraps from top to zero
// - select rising ends read at any bit
// - read refused while programming runs
// - write end starts timed cycle, then busy clears
// - further bytes fill same page, one cycle
// - page pointer wraps within 64 bytes
// - write needs permit latch set
// - write refused while programming runs
// - write discarded unless ended after bit zero
// - write refused into protected region
// - six check bits correct one bit
// - any byte write reprograms whole word
// - erased array, status bits start zero
// - input msb first on rising edges
// - output msb first on falling edges
// - output undriven while deselected
// - clock modes 0,0 and 1,1 both work
// - busy flag high during programming
// - region bits select protected area
module sea_spi_eeprom #(
  parameter int PROG_TIME_US = `SEA_PROG_TIME_US,
  parameter int CLK_MHZ      = `SEA_CLK_MHZ
) (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_n_i,
  // serial bus pins
  input  wire logic                 spi_sck_i,
  input  wire logic                 spi_cs_n_i,
  input  wire logic                 spi_mosi_i,
  output logic                      spi_miso_o,
  output logic                      spi_miso_oe_o,
  // protection bits
  input  wire logic                 prot_load_i,
  input  wire sea_pkg::sea_status_s prot_value_i,
  // status
  output sea_pkg::sea_status_s      status_o,
  output logic                      program_busy_flag_o,
  output logic                      program_permit_latch_o
);

  localparam int PROG_RAW    = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = (PROG_RAW < 1) ? 1 : PROG_RAW;
  localparam int TW          = $clog2(PROG_CYCLES + 1);
  localparam int AW          = `SEA_ADDR_W;
  localparam int PB          = `SEA_PAGE_BITS;
  localparam int BUF_DEPTH   = `SEA_BUF_DEPTH;
  localparam int BPW         = $clog2(BUF_DEPTH);
  localparam sea_pkg::sea_cw_s ERASED = sea_pkg::sea_ecc_encode(`SEA_ERASED_WORD);

  // reset release
  logic rst_sync_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {rst_n_reg, rst_sync_reg} <= 2'h0;
    else
      {rst_n_reg, rst_sync_reg} <= {rst_sync_reg, 1'b1};
  end

  // pin synchronisers
  logic sck_meta_reg, sck_sync_reg, sck_last_reg;
  logic cs_meta_reg, cs_sync_reg, cs_last_reg;
  logic mosi_meta_reg, mosi_sync_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      {sck_last_reg, sck_sync_reg, sck_meta_reg} <= 3'h0;
      {cs_last_reg, cs_sync_reg, cs_meta_reg}    <= 3'h7;
      {mosi_sync_reg, mosi_meta_reg}             <= 2'h0;
    end
    else
    begin
      {sck_last_reg, sck_sync_reg, sck_meta_reg} <= {sck_sync_reg, sck_meta_reg, spi_sck_i};
      {cs_last_reg, cs_sync_reg, cs_meta_reg}    <= {cs_sync_reg, cs_meta_reg, spi_cs_n_i};
      {mosi_sync_reg, mosi_meta_reg}             <= {mosi_meta_reg, spi_mosi_i};
    end
  end

  // edges only count while selected; idle level is irrelevant
  wire rise_ev = sck_sync_reg & ~sck_last_reg & ~cs_sync_reg;
  wire fall_ev = ~sck_sync_reg & sck_last_reg & ~cs_sync_reg;
  wire cs_rise = cs_sync_reg & ~cs_last_reg;

  // registers
  sea_pkg::sea_state_e          state_reg, state_next;
  sea_pkg::sea_status_s         status_reg;
  logic [2:0]                   bit_cnt_reg;
  logic [7:0]                   shift_reg;
  logic                         rd_mode_reg;
  logic                         cmd_permit_reg;
  logic                         addr_half_reg;
  logic [7:0]                   addr_hi_reg;
  logic [AW-1:0]                wptr_reg;
  logic [(1 << PB)-1:0]         mask_reg;
  logic                         got_byte_reg;
  logic                         permit_reg;
  logic                         busy_reg;
  logic [TW-1:0]                timer_reg;
  logic                         seq_on_reg;
  logic [`SEA_PAGE_WORD_AW-1:0] seq_word_reg;
  logic [2:0]                   seq_step_reg;
  logic [AW-PB-1:0]             prog_page_reg;
  logic [`SEA_WORD_BITS-1:0]    acc_reg, acc_next;
  logic                         fetch_on_reg;
  logic [AW-1:0]                fetch_addr_reg;
  logic                         pend_reg;
  logic [`SEA_BYTE_SEL_W-1:0]   pend_bsel_reg;
  logic [7:0]                   fifo_reg [BUF_DEPTH];
  logic [BPW-1:0]               fifo_wr_reg, fifo_rd_reg;
  logic [BPW:0]                 fifo_cnt_reg;
  logic [2:0]                   out_cnt_reg;
  logic [7:0]                   oshift_reg;
  logic                         miso_reg;

  // memory ports
  logic [`SEA_CW_BITS-1:0]   arr_rdata;
  logic [7:0]                pbuf_rdata;
  logic [`SEA_WORD_BITS-1:0] dec_data;

  // serial input decode
  wire [7:0] byte_in   = {shift_reg[6:0], mosi_sync_reg};
  wire       byte_done = rise_ev & (bit_cnt_reg == 3'h7);
  wire       op_read   = byte_in == `SEA_OP_READ;
  wire       op_write  = byte_in == `SEA_OP_WRITE;
  wire       op_cmd    = (byte_in == `SEA_OP_PERMIT) | (byte_in == `SEA_OP_REVOKE);
  wire       opc_done  = byte_done & (state_reg == sea_pkg::PH_OPC);
  wire       addr_byte = byte_done & (state_reg == sea_pkg::PH_ADDR);
  wire       addr_done = addr_byte & addr_half_reg;
  wire       data_byte = byte_done & (state_reg == sea_pkg::PH_WDAT);

  // high byte first, top bit dropped
  wire [AW-1:0] addr_full = {addr_hi_reg[AW-9:0], byte_in};

  // protected region from the two region bits
  wire [1:0] region    = {status_reg.hi, status_reg.lo};
  wire       in_half   = addr_full[AW-1];
  wire       in_quart  = &addr_full[AW-1:AW-2];
  wire       page_lock = (region == `SEA_REGION_ALL)
                       | ((region == `SEA_REGION_HALF) & in_half)
                       | ((region == `SEA_REGION_QUART) & in_quart);

  // busy refuses reads and writes, writes also need the permit latch
  wire rd_ok = op_read & ~busy_reg;
  wire wr_ok = op_write & ~busy_reg & permit_reg;

  sea_pkg::sea_state_e opc_target, addr_target;
  assign opc_target  = (rd_ok | wr_ok) ? sea_pkg::PH_ADDR
                     : (op_cmd & ~busy_reg) ? sea_pkg::PH_CMD : sea_pkg::PH_SKIP;
  assign addr_target = rd_mode_reg ? sea_pkg::PH_RDAT
                     : page_lock ? sea_pkg::PH_SKIP : sea_pkg::PH_WDAT;

  // select high drops any transfer at any bit
  always_comb
  begin
    state_next = state_reg;
    if (cs_sync_reg)
      state_next = sea_pkg::PH_IDLE;
    else
    begin
      unique case (state_reg)
        sea_pkg::PH_IDLE: state_next = sea_pkg::PH_OPC;
        sea_pkg::PH_OPC:  state_next = byte_done ? opc_target : state_reg;
        sea_pkg::PH_ADDR: state_next = addr_done ? addr_target : state_reg;
        sea_pkg::PH_CMD:  state_next = byte_done ? sea_pkg::PH_SKIP : state_reg;
        sea_pkg::PH_RDAT: state_next = state_reg;
        sea_pkg::PH_WDAT: state_next = state_reg;
        sea_pkg::PH_SKIP: state_next = state_reg;
      endcase
    end
  end

  // ending events
  wire prog_start = cs_rise & (state_reg == sea_pkg::PH_WDAT)
                  & (bit_cnt_reg == 3'h0) & got_byte_reg;
  wire cmd_apply  = cs_rise & (state_reg == sea_pkg::PH_CMD) & (bit_cnt_reg == 3'h0);
  wire seq_last   = seq_on_reg & (seq_step_reg == `SEA_SEQ_LAST) & (&seq_word_reg);
  wire prog_done  = busy_reg & (timer_reg == '0) & ~seq_on_reg;

  // serial front end
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg      <= sea_pkg::PH_IDLE;
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 8'h00;
      rd_mode_reg    <= 1'b0;
      cmd_permit_reg <= 1'b0;
      addr_half_reg  <= 1'b0;
      addr_hi_reg    <= 8'h00;
    end
    else
    begin
      state_reg     <= state_next;
      bit_cnt_reg   <= cs_sync_reg ? 3'h0 : bit_cnt_reg + {2'h0, rise_ev};
      shift_reg     <= rise_ev ? byte_in : shift_reg;
      addr_half_reg <= ~cs_sync_reg & (addr_half_reg ^ addr_byte);
      if (opc_done)
      begin
        rd_mode_reg    <= op_read;
        cmd_permit_reg <= byte_in == `SEA_OP_PERMIT;
      end
      if (addr_byte & ~addr_half_reg)
        addr_hi_reg <= byte_in;
    end
  end

  // write data capture into the page buffer
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      wptr_reg     <= '0;
      mask_reg     <= '0;
      got_byte_reg <= 1'b0;
    end
    else
    begin
      if (addr_done)
        wptr_reg <= addr_full;
      else if (data_byte)
        wptr_reg <= {wptr_reg[AW-1:PB], wptr_reg[PB-1:0] + 1'b1};
      // only an accepted write may clear the mask the sequencer is reading
      if (opc_done & wr_ok)
        mask_reg <= '0;
      else if (data_byte)
        mask_reg[wptr_reg[PB-1:0]] <= 1'b1;
      got_byte_reg <= ~cs_sync_reg & (got_byte_reg | data_byte);
    end
  end

  // permit latch, busy flag, programming timer
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      permit_reg    <= 1'b0;
      busy_reg      <= 1'b0;
      timer_reg     <= '0;
      prog_page_reg <= '0;
      status_reg    <= '0;
    end
    else
    begin
      if (cmd_apply)
        permit_reg <= cmd_permit_reg;
      else if (prog_done)
        permit_reg <= 1'b0;
      busy_reg  <= prog_start | (busy_reg & ~prog_done);
      timer_reg <= prog_start ? TW'(PROG_CYCLES - 1)
                 : (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
      if (prog_start)
        prog_page_reg <= wptr_reg[AW-1:PB];
      if (prot_load_i)
        status_reg <= prot_value_i;
    end
  end

  // page sequencer: read word, merge buffered bytes, rewrite word
  wire [1:0] mbyte     = seq_step_reg[1:0] - 2'h1;
  wire       merge_on  = seq_on_reg & (seq_step_reg != 3'h0) & (seq_step_reg != `SEA_SEQ_LAST);
  wire       dirty     = |mask_reg[{seq_word_reg, 2'h0} +: 4];
  wire       arr_we    = seq_on_reg & (seq_step_reg == `SEA_SEQ_LAST) & dirty;
  wire [PB-1:0] pb_addr = seq_on_reg ? {seq_word_reg, seq_step_reg[1:0]} : wptr_reg[PB-1:0];

  always_comb
  begin
    acc_next = (seq_step_reg == 3'h1) ? dec_data : acc_reg;
    if (mask_reg[{seq_word_reg, mbyte}])
      acc_next[{mbyte, 3'h0} +: 8] = pbuf_rdata;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      seq_on_reg   <= 1'b0;
      seq_word_reg <= '0;
      seq_step_reg <= 3'h0;
      acc_reg      <= '0;
    end
    else
    begin
      seq_on_reg   <= prog_start | (seq_on_reg & ~seq_last);
      seq_step_reg <= (~seq_on_reg | (seq_step_reg == `SEA_SEQ_LAST)) ? 3'h0
                    : seq_step_reg + 3'h1;
      if (~seq_on_reg)
        seq_word_reg <= '0;
      else if (seq_step_reg == `SEA_SEQ_LAST)
        seq_word_reg <= seq_word_reg + 1'b1;
      if (merge_on)
        acc_reg <= acc_next;
    end
  end

  // read prefetch, stalled by the output buffer
  wire       buf_in_ready = fifo_cnt_reg != (BPW + 1)'(BUF_DEPTH);
  wire       fetch_issue  = fetch_on_reg & ~pend_reg & buf_in_ready;
  wire       buf_in_valid = pend_reg & fetch_on_reg;
  wire [7:0] fetch_byte   = dec_data[{pend_bsel_reg, 3'h0} +: 8];
  wire       buf_out_valid = fifo_cnt_reg != '0;
  wire       out_load     = fall_ev & (state_reg == sea_pkg::PH_RDAT) & (out_cnt_reg == 3'h0);
  wire       buf_push     = buf_in_valid & buf_in_ready;
  wire       buf_pop      = buf_out_valid & out_load;
  wire [7:0] buf_head     = fifo_reg[fifo_rd_reg];

  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      fetch_on_reg   <= 1'b0;
      fetch_addr_reg <= '0;
      pend_reg       <= 1'b0;
      pend_bsel_reg  <= '0;
    end
    else
    begin
      fetch_on_reg <= ~cs_sync_reg & (fetch_on_reg | (addr_done & rd_mode_reg));
      pend_reg     <= fetch_issue;
      if (addr_done)
        fetch_addr_reg <= addr_full;
      else if (fetch_issue)
        fetch_addr_reg <= fetch_addr_reg + 1'b1;
      if (fetch_issue)
        pend_bsel_reg <= fetch_addr_reg[`SEA_BYTE_SEL_W-1:0];
    end
  end

  // two-entry byte buffer, flushed on deselect
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      fifo_wr_reg  <= '0;
      fifo_rd_reg  <= '0;
      fifo_cnt_reg <= '0;
    end
    else if (cs_sync_reg)
    begin
      fifo_wr_reg  <= '0;
      fifo_rd_reg  <= '0;
      fifo_cnt_reg <= '0;
    end
    else
    begin
      fifo_wr_reg  <= fifo_wr_reg + BPW'(buf_push);
      fifo_rd_reg  <= fifo_rd_reg + BPW'(buf_pop);
      fifo_cnt_reg <= fifo_cnt_reg + (BPW + 1)'(buf_push) - (BPW + 1)'(buf_pop);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (buf_push)
      fifo_reg[fifo_wr_reg] <= fetch_byte;
  end

  // output shifter on falling edges
  always_ff @(posedge clk_sys_i or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      out_cnt_reg <= 3'h0;
      oshift_reg  <= 8'h00;
      miso_reg    <= 1'b0;
    end
    else if (cs_sync_reg)
      out_cnt_reg <= 3'h0;
    else if (fall_ev & (state_reg == sea_pkg::PH_RDAT))
    begin
      out_cnt_reg <= out_cnt_reg + 3'h1;
      miso_reg    <= out_load ? buf_head[7] : oshift_reg[7];
      oshift_reg  <= out_load ? {buf_head[6:0], 1'b0} : {oshift_reg[6:0], 1'b0};
    end
  end

  // memories
  sea_mem #(
    .WIDTH (`SEA_CW_BITS),
    .AW    (`SEA_WORD_AW),
    .INIT  (ERASED)
  ) u_array (
    .clk_i   (clk_sys_i),
    .we_i    (arr_we),
    .addr_i  (seq_on_reg ? {prog_page_reg, seq_word_reg}
                         : fetch_addr_reg[AW-1:`SEA_BYTE_SEL_W]),
    .wdata_i (sea_pkg::sea_ecc_encode(acc_reg)),
    .rdata_o (arr_rdata)
  );

  sea_mem #(
    .WIDTH (8),
    .AW    (PB),
    .INIT  (8'h00)
  ) u_page_buf (
    .clk_i   (clk_sys_i),
    .we_i    (data_byte),
    .addr_i  (pb_addr),
    .wdata_i (byte_in),
    .rdata_o (pbuf_rdata)
  );

  assign dec_data = sea_pkg::sea_ecc_decode(sea_pkg::sea_cw_s'(arr_rdata));

  // outputs
  assign spi_miso_o             = miso_reg;
  assign spi_miso_oe_o          = (state_reg == sea_pkg::PH_RDAT) & ~cs_sync_reg;
  assign status_o               = status_reg;
  assign program_busy_flag_o    = busy_reg;
  assign program_permit_latch_o = permit_reg;

endmodule

// *** verification/sea_spi_eeprom_sva.sv ***
// port assertions of the serial eeprom slave
module sea_spi_eeprom_sva #(
  parameter int PROG_TIME_US = 1000,
  parameter int CLK_MHZ      = 25
) (
  // clock and reset
  input wire logic                 clk_sys_i,
  input wire logic                 reset_n_i,
  // serial pins
  input wire logic                 spi_sck_i,
  input wire logic                 spi_cs_n_i,
  input wire logic                 spi_mosi_i,
  input wire logic                 spi_miso_o,
  input wire logic                 spi_miso_oe_o,
  // protection and status
  input wire logic                 prot_load_i,
  input wire sea_pkg::sea_status_s prot_value_i,
  input wire sea_pkg::sea_status_s status_o,
  input wire logic                 program_busy_flag_o,
  input wire logic                 program_permit_latch_o
);
  localparam int PC = PROG_TIME_US * CLK_MHZ;
  int unsigned          busy_cnt_reg;
  sea_pkg::sea_status_s prot_reg;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  // length of the current busy stretch
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy_cnt_reg <= 0;
      prot_reg     <= '0;
    end
    else
    begin
      busy_cnt_reg <= program_busy_flag_o ? busy_cnt_reg + 1 : 0;
      if (prot_load_i)
        prot_reg <= prot_value_i;
    end
  end
  sequence s_desel;
    spi_cs_n_i [*6];
  endsequence
  sequence s_prog_end;
    program_busy_flag_o ##1 !program_busy_flag_o;
  endsequence
  property p_oe_desel;
    s_desel |-> !spi_miso_oe_o;
  endproperty
  property p_busy_start;
    $rose(program_busy_flag_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
  endproperty
  property p_prog_len;
    s_prog_end |-> busy_cnt_reg >= PC - 1 && busy_cnt_reg <= PC + 200;
  endproperty
  property p_permit_clr;
    s_prog_end |-> !program_permit_latch_o;
  endproperty
  property p_permit_rise;
    $rose(program_permit_latch_o) |-> spi_cs_n_i && !program_busy_flag_o;
  endproperty
  property p_oe_busy;
    program_busy_flag_o |-> !spi_miso_oe_o;
  endproperty
  property p_miso_fall;
    spi_miso_oe_o && $past(spi_miso_oe_o) && $changed(spi_miso_o) |-> !$past(spi_sck_i);
  endproperty
  property p_prot;
    prot_load_i |=> ##[0:1] status_o == prot_reg;
  endproperty
  a_oe_desel: assert property (p_oe_desel)
    else $error("output enabled while deselected");
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose without select high");
  a_prog_len: assert property (p_prog_len)
    else $error("busy length wrong");
  a_permit_clr: assert property (p_permit_clr)
    else $error("permit kept after programming");
  a_permit_rise: assert property (p_permit_rise)
    else $error("permit set at wrong time");
  a_oe_busy: assert property (p_oe_busy)
    else $error("read answered while busy");
  a_miso_fall: assert property (p_miso_fall)
    else $error("output changed outside low clock");
  a_prot: assert property (p_prot)
    else $error("protect bits not loaded");
endmodule

bind sea_spi_eeprom sea_spi_eeprom_sva #(
  .PROG_TIME_US(PROG_TIME_US),
  .CLK_MHZ     (CLK_MHZ)
) u_sva (
  .clk_sys_i             (clk_sys_i),
  .reset_n_i             (reset_n_i),
  .spi_sck_i             (spi_sck_i),
  .spi_cs_n_i            (spi_cs_n_i),
  .spi_mosi_i            (spi_mosi_i),
  .spi_miso_o            (spi_miso_o),
  .spi_miso_oe_o         (spi_miso_oe_o),
  .prot_load_i           (prot_load_i),
  .prot_value_i          (prot_value_i),
  .status_o              (status_o),
  .program_busy_flag_o   (program_busy_flag_o),
  .program_permit_latch_o(program_permit_latch_o)
);

// *** verification/sea_spi_master.sv ***
// serial bus master model driving the eeprom pins
module sea_spi_master (
  // clock
  input  wire logic clk_i,
  // serial pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol = 1'b0;
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // idle level first, then select
  task automatic sel();
    sck_o <= cpol;
    wait_clk(4);
    cs_n_o <= 1'b0;
    wait_clk(4);
  endtask
  // msb first, change low, sample before rising
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = '0;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck_o  <= 1'b0;
      mosi_o <= tx[i];
      wait_clk(4);
      rx[i] = miso_i;
      sck_o <= 1'b1;
      wait_clk(4);
    end
  endtask
  // release select; data line shows inverse
  task automatic desel();
    sck_o <= cpol;
    wait_clk(4);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    wait_clk(8);
  endtask
endmodule

// *** verification/sea_spi_eeprom_tb.sv ***
// testbench of the serial eeprom slave
module sea_spi_eeprom_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk_sys = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 prot_load = 1'b0;
  sea_pkg::sea_status_s prot_val = '0;
  sea_pkg::sea_status_s stat;
  logic                 sck, cs_n, mosi, miso, oe, busy, permit;
  wire                  miso_w;
  logic [7:0]           rx;
  int                   bad_count = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  always #20 clk_sys = ~clk_sys;
  assign miso_w = oe ? miso : 1'bz;
  sea_spi_master m (
    .clk_i(clk_sys), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
  sea_spi_eeprom #(.PROG_TIME_US(40)) dut (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe), .prot_load_i(prot_load),
    .prot_value_i(prot_val), .status_o(stat), .program_busy_flag_o(busy),
    .program_permit_latch_o(permit));
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    m.sel();
    m.xfer(op, 8, rx);
    m.xfer(a[15:8], 8, rx);
    m.xfer(a[7:0], 8, rx);
  endtask
  task automatic op1(input logic [7:0] op);
    m.sel();
    m.xfer(op, 8, rx);
    m.desel();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int tail);
    hdr(8'h02, a);
    foreach (d[i]) m.xfer(d[i], 8, rx);
    if (tail > 0) m.xfer(8'h5a, tail, rx);
    m.desel();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
    hdr(8'h03, a);
    foreach (e[i])
    begin
      m.xfer(8'h00, 8, rx);
      chk(rx, e[i]);
    end
    m.desel();
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    chk(8'(busy), 8'h00);
  endtask
  task automatic prot(input sea_pkg::sea_status_s v);
    prot_val  <= v;
    prot_load <= 1'b1;
    @(posedge clk_sys);
    prot_load <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(8'(stat), 8'(v));
  endtask
  task automatic t_page();
    chk(8'(stat), 8'h00);
    rd(16'h0000, '{8'hff, 8'hff});
    op1(8'h06);
    chk(8'(permit), 8'h01);
    wr(16'h003e, '{8'ha1, 8'hb2, 8'hc3}, 0);
    chk(8'(busy), 8'h01);
    idle();
    chk(8'(permit), 8'h00);
    rd(16'h803e, '{8'ha1, 8'hb2, 8'hff});
    rd(16'h0000, '{8'hc3, 8'hff});
    $display("page test done");
  endtask
  task automatic t_refuse();
    wr(16'h0200, '{8'h77}, 0);
    chk(8'(busy), 8'h00);
    op1(8'h06);
    wr(16'h0200, '{8'h77}, 3);
    chk(8'(busy), 8'h00);
    prot(3'b101);
    op1(8'h06);
    wr(16'h6000, '{8'h77}, 0);
    chk(8'(busy), 8'h00);
    prot(3'b000);
    rd(16'h0200, '{8'hff});
    rd(16'h6000, '{8'hff});
    $display("refusal test done");
  endtask
  task automatic t_busy();
    op1(8'h06);
    wr(16'h0100, '{8'h11}, 0);
    hdr(8'h03, 16'h0100);
    m.xfer(8'h00, 8, rx);
    chk(8'(oe), 8'h00);
    m.desel();
    wr(16'h0104, '{8'h22}, 0);
    idle();
    rd(16'h0100, '{8'h11, 8'hff, 8'hff, 8'hff, 8'hff});
    dut.u_array.mem[64][0] = ~dut.u_array.mem[64][0];
    rd(16'h0100, '{8'h11});
    $display("busy test done");
  endtask
  task automatic t_mode11();
    m.cpol = 1'b1;
    rd(16'h7fff, '{8'hff, 8'hc3});
    hdr(8'h03, 16'h003e);
    m.xfer(8'h00, 3, rx);
    chk(8'(rx[7:5]), 8'h05);
    m.desel();
    chk(8'(oe), 8'h00);
    rd(16'h003f, '{8'hb2});
    m.cpol = 1'b0;
    $display("mode test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    t_page();
    t_refuse();
    t_busy();
    t_mode11();
    wrap_up();
  end
endmodule
